// >>> logic/imrs_master.sv
// Two-wire bus master: byte reception, start/stop generation, enable and shared interrupt
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module imrs_master (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bit_clock_in,
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe,
    input  wire logic        serial_data_pin_i,
    output logic             serial_data_pin_o,
    output logic             serial_data_pin_oe,
    output logic             irq
);

    imrs_pkg::imrs_state_t q;
    imrs_pkg::imrs_state_t n;

    // =====================================================================
    // Next-state logic
    // =====================================================================
    always_comb begin
        logic tick;
        logic sda_v;
        logic scl_v;
        logic acc;
        logic wr;
        logic rd;
        tick  = 1'b0;
        sda_v = 1'b0;
        scl_v = 1'b0;
        acc   = 1'b0;
        wr    = 1'b0;
        rd    = 1'b0;
        n     = q;

        // Three-stage synchronisers; stage one feeds stage two only
        n.sda_s1  = serial_data_pin_i;
        n.sda_s2  = q.sda_s1;
        n.sda_s3  = q.sda_s2;
        n.scl_s1  = serial_clock_pin_i;
        n.scl_s2  = q.scl_s1;
        n.scl_s3  = q.scl_s2;
        n.bclk_s1 = bit_clock_in;
        n.bclk_s2 = q.bclk_s1;
        n.bclk_s3 = q.bclk_s2;

        // Noise filter: only accept a level seen on two samples in a row
        if (!q.noise_filter || (q.sda_s2 == q.sda_s3)) begin
            n.sda_f = q.sda_s2;
        end
        if (!q.noise_filter || (q.scl_s2 == q.scl_s3)) begin
            n.scl_f = q.scl_s2;
        end
        sda_v = q.sda_f;
        scl_v = q.scl_f;

        // Every timer edge is one third of a bit period
        tick = q.bclk_s2 ^ q.bclk_s3;

        // APB: pready answers in the access cycle, read data caught at setup
        acc       = psel && penable && q.pready;
        wr        = acc && pwrite;
        rd        = acc && !pwrite;
        n.pready  = psel && !penable;
        n.pslverr = 1'b0;
        if (psel && !penable) begin
            n.prdata = 32'h0000_0000;  // Reserved bits read zero
            unique case (paddr)
                imrs_pkg::IMRS_ADDR_ENABLE: begin
                    n.prdata[imrs_pkg::IMRS_EN_BIT] = q.module_enable_bit;
                end
                imrs_pkg::IMRS_ADDR_CONTROL: begin
                    n.prdata[imrs_pkg::IMRS_CTL_RECEIVE_BUSY_FLAG] = q.receive_busy_flag;
                    n.prdata[imrs_pkg::IMRS_CTL_TRANSMIT_BUSY_FLAG] = q.transmit_busy_flag;
                    n.prdata[imrs_pkg::IMRS_CTL_NOISE] = q.noise_filter;
                    n.prdata[imrs_pkg::IMRS_CTL_STOP]  = q.stop_request;
                    n.prdata[imrs_pkg::IMRS_CTL_START] = q.start_request;
                end
                imrs_pkg::IMRS_ADDR_DATA: begin
                    n.prdata[imrs_pkg::IMRS_DAT_RECEIVE_BUFFER_READY]    = q.receive_buffer_ready;
                    n.prdata[imrs_pkg::IMRS_DAT_RXREQ]    = q.receive_request;
                    n.prdata[imrs_pkg::IMRS_DAT_TXREQ]    = q.transmit_request;
                    n.prdata[imrs_pkg::IMRS_DAT_RESPONSE] = q.response_bit;
                    n.prdata[7:0]                         = q.data_byte_field;
                end
                imrs_pkg::IMRS_ADDR_IRQEN: begin
                    n.prdata[imrs_pkg::IMRS_ICTL_TX_EMPTY_IRQ_ENABLE] = q.tx_empty_irq_enable;
                    n.prdata[imrs_pkg::IMRS_ICTL_RX_FULL_IRQ_ENABLE] = q.rx_full_irq_enable;
                end
                default: begin
                    n.pslverr = 1'b1;  // Unmapped address
                end
            endcase
        end

        // Software writes and read side effects; hardware sets below win
        if (wr && (paddr == imrs_pkg::IMRS_ADDR_ENABLE)) begin
            n.module_enable_bit = pwdata[imrs_pkg::IMRS_EN_BIT];
        end
        if (wr && (paddr == imrs_pkg::IMRS_ADDR_CONTROL)) begin
            n.noise_filter = pwdata[imrs_pkg::IMRS_CTL_NOISE];
        end
        if (wr && (paddr == imrs_pkg::IMRS_ADDR_DATA)) begin
            n.data_byte_field = pwdata[7:0];
            n.response_bit    = pwdata[imrs_pkg::IMRS_DAT_RESPONSE];
            n.tx_cause        = 1'b0;
        end
        if (wr && (paddr == imrs_pkg::IMRS_ADDR_IRQEN)) begin
            n.tx_empty_irq_enable = pwdata[imrs_pkg::IMRS_ICTL_TX_EMPTY_IRQ_ENABLE];
            n.rx_full_irq_enable  = pwdata[imrs_pkg::IMRS_ICTL_RX_FULL_IRQ_ENABLE];
        end
        if (rd && (paddr == imrs_pkg::IMRS_ADDR_DATA)) begin
            n.receive_buffer_ready = 1'b0;
            n.rx_cause             = 1'b0;
        end

        // Bus engine; disabling drops the phase, both pins and both busy flags at once
        if (!q.module_enable_bit) begin
            n.phase              = imrs_pkg::IMRS_PH_IDLE;
            n.scl_oe             = 1'b0;
            n.sda_oe             = 1'b0;
            n.transmit_busy_flag = 1'b0;
            n.receive_busy_flag  = 1'b0;
        end else if (tick) begin
            unique case (q.phase)
                imrs_pkg::IMRS_PH_IDLE: begin
                    if (q.start_request) begin
                        n.phase = imrs_pkg::IMRS_PH_START_REL_SDA;
                    end
                end
                imrs_pkg::IMRS_PH_START_REL_SDA: begin
                    n.sda_oe = 1'b0;
                    n.phase  = imrs_pkg::IMRS_PH_START_REL_SCL;
                end
                imrs_pkg::IMRS_PH_START_REL_SCL: begin
                    n.scl_oe = 1'b0;
                    n.phase  = imrs_pkg::IMRS_PH_START_SDA_LOW;
                end
                imrs_pkg::IMRS_PH_START_SDA_LOW: begin
                    // Wait for clock really high so the start is legal
                    if (scl_v) begin
                        n.sda_oe        = 1'b1;
                        n.start_request = 1'b0;
                        n.phase         = imrs_pkg::IMRS_PH_START_SCL_LOW;
                    end
                end
                imrs_pkg::IMRS_PH_START_SCL_LOW: begin
                    n.scl_oe = 1'b1;
                    n.phase  = imrs_pkg::IMRS_PH_HOLD;
                end
                imrs_pkg::IMRS_PH_HOLD: begin
                    // Bus busy, clock held low; pick the next job by priority
                    if (q.transmit_request) begin
                        n.shift              = q.data_byte_field;
                        n.transmit_request   = 1'b0;
                        n.tx_cause           = 1'b1;
                        n.transmit_busy_flag = 1'b1;
                        n.is_rx              = 1'b0;
                        n.slot               = imrs_pkg::IMRS_SLOT_FIRST;
                        n.phase              = imrs_pkg::IMRS_PH_BIT_LOW;
                    end else if (q.receive_request) begin
                        n.receive_busy_flag = 1'b1;
                        n.is_rx             = 1'b1;
                        n.slot              = imrs_pkg::IMRS_SLOT_FIRST;
                        n.phase             = imrs_pkg::IMRS_PH_BIT_LOW;
                    end else if (q.start_request) begin
                        n.phase = imrs_pkg::IMRS_PH_START_REL_SDA;
                    end else if (q.stop_request) begin
                        n.phase = imrs_pkg::IMRS_PH_STOP_SDA_LOW;
                    end
                end
                imrs_pkg::IMRS_PH_BIT_LOW: begin
                    // Move data while the clock stays low; release comes a tick later
                    if (q.is_rx) begin
                        if (q.slot == imrs_pkg::IMRS_SLOT_ACK) begin
                            n.sda_oe = !q.response_bit;
                        end else begin
                            n.sda_oe = 1'b0;
                        end
                    end else begin
                        if (q.slot == imrs_pkg::IMRS_SLOT_ACK) begin
                            n.sda_oe = 1'b0;
                        end else begin
                            n.sda_oe = !q.shift[7];
                        end
                    end
                    n.phase  = imrs_pkg::IMRS_PH_BIT_HIGH;
                end
                imrs_pkg::IMRS_PH_BIT_HIGH: begin
                    // Data never moves with the clock edge, so no false start or stop
                    // A slave holding the clock low stretches this phase
                    if (q.scl_oe) begin
                        n.scl_oe = 1'b0;
                    end else if (scl_v) begin
                        n.scl_oe = 1'b1;
                        if (q.slot == imrs_pkg::IMRS_SLOT_ACK) begin
                            if (!q.is_rx) begin
                                n.response_bit = sda_v;
                            end
                            n.transmit_busy_flag = 1'b0;
                            n.receive_busy_flag  = 1'b0;
                            n.phase              = imrs_pkg::IMRS_PH_HOLD;
                        end else begin
                            n.shift = {q.shift[6:0], sda_v};
                            if (q.is_rx && (q.slot == imrs_pkg::IMRS_SLOT_FIRST)) begin
                                n.receive_request = 1'b0;
                            end
                            if (q.is_rx && (q.slot == imrs_pkg::IMRS_SLOT_LAST)) begin
                                n.data_byte_field      = {q.shift[6:0], sda_v};
                                n.receive_buffer_ready = 1'b1;
                                n.rx_cause             = 1'b1;
                            end
                            n.slot  = q.slot + 4'h1;
                            n.phase = imrs_pkg::IMRS_PH_BIT_LOW;
                        end
                    end
                end
                imrs_pkg::IMRS_PH_STOP_SDA_LOW: begin
                    n.sda_oe = 1'b1;
                    n.phase  = imrs_pkg::IMRS_PH_STOP_REL_SCL;
                end
                imrs_pkg::IMRS_PH_STOP_REL_SCL: begin
                    n.scl_oe = 1'b0;
                    n.phase  = imrs_pkg::IMRS_PH_STOP_REL_SDA;
                end
                imrs_pkg::IMRS_PH_STOP_REL_SDA: begin
                    // Data rises only once the clock is seen high
                    if (scl_v) begin
                        n.sda_oe       = 1'b0;
                        n.stop_request = 1'b0;
                        n.phase        = imrs_pkg::IMRS_PH_IDLE;
                    end
                end
                default: begin
                    n.phase = imrs_pkg::IMRS_PH_IDLE;
                end
            endcase
        end

        // Request sets last so a write never loses to an auto-clear
        if (wr && (paddr == imrs_pkg::IMRS_ADDR_CONTROL)) begin
            if (pwdata[imrs_pkg::IMRS_CTL_STOP]) begin
                n.stop_request = 1'b1;
            end
            if (pwdata[imrs_pkg::IMRS_CTL_START]) begin
                n.start_request = 1'b1;
            end
        end
        if (wr && (paddr == imrs_pkg::IMRS_ADDR_DATA)) begin
            if (pwdata[imrs_pkg::IMRS_DAT_TXREQ]) begin
                n.transmit_request = 1'b1;
            end
            if (pwdata[imrs_pkg::IMRS_DAT_RXREQ]) begin
                n.receive_request = 1'b1;
            end
        end

        // One shared request line
        n.irq = (n.tx_cause && n.tx_empty_irq_enable) || (n.rx_cause && n.rx_full_irq_enable);
    end

    // =====================================================================
    // State register
    // =====================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= imrs_pkg::IMRS_STATE_RST;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state record; pins only ever pull low
    assign prdata              = q.prdata;
    assign pready              = q.pready;
    assign pslverr             = q.pslverr;
    assign serial_clock_pin_o  = q.pin_level;
    assign serial_clock_pin_oe = q.scl_oe;
    assign serial_data_pin_o   = q.pin_level;
    assign serial_data_pin_oe  = q.sda_oe;
    assign irq                 = q.irq;

endmodule // imrs_master

// >>> logic/imrs_pkg.sv
// Constants, register map and state types of the two-wire bus master receive/stop block
package imrs_pkg;

    // =====================================================================
    // Register indices (byte address is four times the index)
    // =====================================================================
    localparam logic [15:0] IMRS_IDX_ENABLE  = 16'h4340;
    localparam logic [15:0] IMRS_IDX_CONTROL = 16'h4342;
    localparam logic [15:0] IMRS_IDX_DATA    = 16'h4344;
    localparam logic [15:0] IMRS_IDX_IRQEN   = 16'h4346;
    localparam logic [31:0] IMRS_ADDR_ENABLE  = {14'h0000, IMRS_IDX_ENABLE, 2'h0};
    localparam logic [31:0] IMRS_ADDR_CONTROL = {14'h0000, IMRS_IDX_CONTROL, 2'h0};
    localparam logic [31:0] IMRS_ADDR_DATA    = {14'h0000, IMRS_IDX_DATA, 2'h0};
    localparam logic [31:0] IMRS_ADDR_IRQEN   = {14'h0000, IMRS_IDX_IRQEN, 2'h0};

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int IMRS_EN_BIT       = 0;
    localparam int IMRS_CTL_START    = 0;
    localparam int IMRS_CTL_STOP     = 1;
    localparam int IMRS_CTL_NOISE    = 4;
    localparam int IMRS_CTL_TRANSMIT_BUSY_FLAG    = 8;
    localparam int IMRS_CTL_RECEIVE_BUSY_FLAG    = 9;
    localparam int IMRS_DAT_RESPONSE = 8;
    localparam int IMRS_DAT_TXREQ    = 9;
    localparam int IMRS_DAT_RXREQ    = 10;
    localparam int IMRS_DAT_RECEIVE_BUFFER_READY    = 11;
    localparam int IMRS_ICTL_TX_EMPTY_IRQ_ENABLE   = 0;
    localparam int IMRS_ICTL_RX_FULL_IRQ_ENABLE   = 1;

    // =====================================================================
    // Bit slots within one byte transfer
    // =====================================================================
    localparam logic [3:0] IMRS_SLOT_FIRST = 4'h0;
    localparam logic [3:0] IMRS_SLOT_LAST  = 4'h7;
    localparam logic [3:0] IMRS_SLOT_ACK   = 4'h8;

    // =====================================================================
    // Engine phases and full state record
    // =====================================================================
    typedef enum logic [3:0] {
        IMRS_PH_IDLE,
        IMRS_PH_START_REL_SDA,
        IMRS_PH_START_REL_SCL,
        IMRS_PH_START_SDA_LOW,
        IMRS_PH_START_SCL_LOW,
        IMRS_PH_HOLD,
        IMRS_PH_BIT_LOW,
        IMRS_PH_BIT_HIGH,
        IMRS_PH_STOP_SDA_LOW,
        IMRS_PH_STOP_REL_SCL,
        IMRS_PH_STOP_REL_SDA
    } imrs_phase_t;

    typedef struct packed {
        logic        sda_s1, sda_s2, sda_s3, sda_f;
        logic        scl_s1, scl_s2, scl_s3, scl_f;
        logic        bclk_s1, bclk_s2, bclk_s3;
        logic        module_enable_bit;
        logic        noise_filter;
        logic        start_request;
        logic        stop_request;
        logic        transmit_request;
        logic        receive_request;
        logic        response_bit;
        logic [7:0]  data_byte_field;
        logic        receive_buffer_ready;
        logic        transmit_busy_flag;
        logic        receive_busy_flag;
        logic        tx_empty_irq_enable;
        logic        rx_full_irq_enable;
        logic        tx_cause;
        logic        rx_cause;
        imrs_phase_t phase;
        logic        is_rx;
        logic [3:0]  slot;
        logic [7:0]  shift;
        logic        scl_oe;
        logic        sda_oe;
        logic        pin_level;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } imrs_state_t;

    localparam imrs_state_t IMRS_STATE_RST = '{phase: IMRS_PH_IDLE, default: '0};

endpackage

// >>> verif/i2c_master_receive_stop_irq_tb.sv
// Self-checking bench: register access, receive, interrupts, repeated start and stop
`timescale 1ns/1ps

module i2c_master_receive_stop_irq_tb;
    // ====================
    // Stimulus and wiring
    // ====================
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        bclk = 1'h0;
    logic        scl_oe;
    logic        sda_oe;
    logic        s_oe;
    logic        irq;
    logic [7:0]  addr_seen;
    logic        host_resp;
    logic [7:0]  starts;
    logic [7:0]  stops;
    logic [31:0] r;
    logic        e;
    logic [7:0]  n;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    wire         scl = ~scl_oe;
    wire         sda = ~(sda_oe | s_oe);

    imrs_master uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bit_clock_in(bclk), .serial_clock_pin_i(scl), .serial_clock_pin_o(),
        .serial_clock_pin_oe(scl_oe), .serial_data_pin_i(sda), .serial_data_pin_o(),
        .serial_data_pin_oe(sda_oe), .irq(irq)
    );
    imrs_slave slave (.scl(scl), .sda(sda), .sda_oe(s_oe), .addr_seen(addr_seen),
        .host_resp(host_resp), .starts(starts), .stops(stops));

    // Bus clock and free-running bit clock of unrelated phase
    always #2.5 pclk = ~pclk;
    always #40 bclk = ~bclk;

    // Hang guard, far above the thousand or so cycles the run needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            tally_and_finish();
        end
    end

    // ====================
    // Tasks
    // ====================
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; answer taken at the edge that sees pready high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd_q, output logic err);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd_q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'h1, a, d, r, e);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    task automatic poll(input logic [31:0] a, input int b, input logic v);
        do apb(1'h0, a, 32'h0, r, e); while (r[b] !== v);
    endtask

    // Level settled before this edge is the one compared
    task automatic irq_is(input logic v);
        @(posedge pclk);
        chk({31'h0, irq}, {31'h0, v});
    endtask

    // ====================
    // Main sequence
    // ====================
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rd(imrs_pkg::IMRS_ADDR_ENABLE, 32'h0);
        rd(imrs_pkg::IMRS_ADDR_CONTROL, 32'h0);
        rd(imrs_pkg::IMRS_ADDR_DATA, 32'h0);
        rd(imrs_pkg::IMRS_ADDR_IRQEN, 32'h0);
        rd(32'h0000_0004, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(imrs_pkg::IMRS_ADDR_ENABLE, 32'h1);
        wr(imrs_pkg::IMRS_ADDR_IRQEN, 32'h1);
        n = starts;
        wr(imrs_pkg::IMRS_ADDR_CONTROL, 32'h1);
        poll(imrs_pkg::IMRS_ADDR_CONTROL, imrs_pkg::IMRS_CTL_START, 1'h0);
        chk({24'h0, starts}, {24'h0, n + 8'h01});
        // Read address with transmit and receive requested together
        wr(imrs_pkg::IMRS_ADDR_DATA, 32'h06A1);
        poll(imrs_pkg::IMRS_ADDR_DATA, imrs_pkg::IMRS_DAT_TXREQ, 1'h0);
        irq_is(1'h1);
        poll(imrs_pkg::IMRS_ADDR_CONTROL, imrs_pkg::IMRS_CTL_RECEIVE_BUSY_FLAG, 1'h1);
        chk({24'h0, addr_seen}, 32'hA1);
        wr(imrs_pkg::IMRS_ADDR_DATA, 32'h0100);
        irq_is(1'h0);
        wr(imrs_pkg::IMRS_ADDR_IRQEN, 32'h2);
        // Busy falls after the byte landed; a data read would clear the cause
        poll(imrs_pkg::IMRS_ADDR_CONTROL, imrs_pkg::IMRS_CTL_RECEIVE_BUSY_FLAG, 1'h0);
        irq_is(1'h1);
        rd(imrs_pkg::IMRS_ADDR_DATA, 32'h095A);
        irq_is(1'h0);
        rd(imrs_pkg::IMRS_ADDR_DATA, 32'h015A);
        chk({31'h0, host_resp}, 32'h1);
        // Repeated start, write address, then stop and disable
        n = starts;
        wr(imrs_pkg::IMRS_ADDR_CONTROL, 32'h1);
        poll(imrs_pkg::IMRS_ADDR_CONTROL, imrs_pkg::IMRS_CTL_START, 1'h0);
        chk({24'h0, starts}, {24'h0, n + 8'h01});
        wr(imrs_pkg::IMRS_ADDR_DATA, 32'h023C);
        poll(imrs_pkg::IMRS_ADDR_DATA, imrs_pkg::IMRS_DAT_TXREQ, 1'h0);
        poll(imrs_pkg::IMRS_ADDR_CONTROL, imrs_pkg::IMRS_CTL_TRANSMIT_BUSY_FLAG, 1'h0);
        chk({24'h0, addr_seen}, 32'h3C);
        repeat (8) @(posedge pclk);
        n = stops;
        wr(imrs_pkg::IMRS_ADDR_CONTROL, 32'h2);
        poll(imrs_pkg::IMRS_ADDR_CONTROL, imrs_pkg::IMRS_CTL_STOP, 1'h0);
        chk({24'h0, stops}, {24'h0, n + 8'h01});
        wr(imrs_pkg::IMRS_ADDR_ENABLE, 32'h0);
        rd(imrs_pkg::IMRS_ADDR_ENABLE, 32'h0);
        tally_and_finish();
    end
endmodule // i2c_master_receive_stop_irq_tb

// >>> verif/imrs_chk.sv
// Port-level assertions for the two-wire bus master receive/stop block
`timescale 1ns/1ps

module imrs_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        bit_clock_in,
    input wire logic        serial_clock_pin_i,
    input wire logic        serial_clock_pin_o,
    input wire logic        serial_clock_pin_oe,
    input wire logic        serial_data_pin_i,
    input wire logic        serial_data_pin_o,
    input wire logic        serial_data_pin_oe,
    input wire logic        irq
);
    // ====================
    // Decoded access cycles
    // ====================
    logic mapped;
    logic rd_en;
    logic rd_ctl;
    logic rd_dat;
    assign mapped = paddr inside {imrs_pkg::IMRS_ADDR_ENABLE, imrs_pkg::IMRS_ADDR_CONTROL,
                                  imrs_pkg::IMRS_ADDR_DATA, imrs_pkg::IMRS_ADDR_IRQEN};
    assign rd_en  = pready && !pwrite && paddr == imrs_pkg::IMRS_ADDR_ENABLE;
    assign rd_ctl = pready && !pwrite && paddr == imrs_pkg::IMRS_ADDR_CONTROL;
    assign rd_dat = pready && !pwrite && paddr == imrs_pkg::IMRS_ADDR_DATA;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Read of a full buffer, then a later setup to the same register
    sequence s_rd_ready;
        rd_dat && prdata[11];
    endsequence
    sequence s_setup_dat;
        psel && !penable && !pwrite && paddr == imrs_pkg::IMRS_ADDR_DATA;
    endsequence

    // ====================
    // Assertions
    // ====================
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_upper_zero: assert property (pready && mapped |-> !pslverr && prdata[31:16] == 16'h0)
        else $error("mapped access flagged or upper half set");
    chk_enable_rsvd: assert property (rd_en |-> prdata[15:1] == 15'h0)
        else $error("enable register reserved bits set");
    chk_ctl_rsvd: assert property (rd_ctl |-> prdata[15:10] == 6'h0 && prdata[7:5] == 3'h0 && prdata[3:2] == 2'h0)
        else $error("control register reserved bits set");
    chk_data_rsvd: assert property (rd_dat |-> prdata[15:12] == 4'h0)
        else $error("data register reserved bits set");
    chk_busy_excl: assert property (rd_ctl |-> !(prdata[8] && prdata[9]))
        else $error("transmit and receive busy together");
    chk_receive_buffer_ready_clear: assert property (s_rd_ready ##[2:4] s_setup_dat ##1 pready |-> !prdata[11])
        else $error("ready flag survived a data read");
    chk_pins_off: assert property (rd_en && !prdata[0] |-> !serial_clock_pin_oe && !serial_data_pin_oe)
        else $error("pins driven while disabled");
    chk_oe_hold: assert property ($changed(serial_clock_pin_oe) |=> $stable(serial_clock_pin_oe) [*3])
        else $error("clock pin changed between bit ticks");
endmodule // imrs_chk

bind imrs_master imrs_chk u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .bit_clock_in, .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe,
    .serial_data_pin_i, .serial_data_pin_o, .serial_data_pin_oe, .irq
);

// >>> verif/imrs_slave.sv
// Behavioural two-wire slave: takes an address, acknowledges it, answers reads with one byte
`timescale 1ns/1ps

module imrs_slave #(
    parameter logic [7:0] REPLY = 8'h5A
) (
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_oe,
    output logic [7:0]      addr_seen,
    output logic            host_resp,
    output logic [7:0]      starts,
    output logic [7:0]      stops
);
    logic [7:0] sh;

    // Counters start clean; the bench compares differences only
    initial begin
        sda_oe = 1'h0;
        starts = 8'h00;
        stops = 8'h00;
    end

    // Stop is data rising while the clock is high
    always @(posedge sda) begin
        if (scl) begin
            stops = stops + 8'h01;
        end
    end

    // One transaction per start; never stretches the clock
    always begin
        @(negedge sda iff scl);
        starts = starts + 8'h01;
        for (int i = 0; i < 8; i++) begin
            @(posedge scl);
            sh = {sh[6:0], sda};
        end
        addr_seen = sh;
        @(negedge scl);
        #10 sda_oe = 1'h1;
        @(negedge scl);
        #10 sda_oe = 1'h0;
        if (sh[0]) begin
            for (int i = 7; i >= 0; i--) begin
                sda_oe = ~REPLY[i];
                @(negedge scl);
                #10;
            end
            sda_oe = 1'h0;
            @(posedge scl);
            host_resp = sda;
        end
    end
endmodule // imrs_slave
